// ===== hdl/qsp_regs.svh
// constants for the serial port boundary
`ifndef QSP_REGS_SVH
`define QSP_REGS_SVH
`define QSP_BURST_FIXED  2'h0
`define QSP_BURST_INCR   2'h1
`define QSP_BURST_WRAP   2'h2
`define QSP_RESP_OKAY    2'h0
`define QSP_RESP_SLVERR  2'h2
`define QSP_SEL_LSB      2
`define QSP_SEL_W        5
`define QSP_LANE_W       8
`define QSP_STRB_FULL    4'hf
`define QSP_DRIVE_N_RST  1'b1
`define QSP_IRQ_RST      1'b0
`define QSP_SCK_RATIO    2
`define QSP_MAX_SS       32
`define QSP_FIFO_DEPTH   32
`define QSP_BITS_LAST    3'h7
`endif

// ===== hdl/qsp_pkg.sv
// types shared by both ends of the serial port boundary
package qsp_pkg;
   typedef enum {QSP_LEGACY, QSP_ENHANCED, QSP_XIP} qsp_mode_t;
   typedef enum {QB_IDLE, QB_BRESP, QB_RWAIT, QB_RDATA} qsp_bus_st_t;
   typedef enum {QE_IDLE, QE_SHIFT} qsp_eng_st_t;
   typedef enum {QH_IDLE, QH_WR, QH_B, QH_AR, QH_R} qsp_host_st_t;
endpackage : qsp_pkg

// ===== hdl/qsp_bus_if.sv
// bus link between the master end and the serial controller end
`timescale 1ns/10ps
interface qsp_bus_if (
   input wire logic mclk,
   input wire logic reset
);
   logic        awvalid, awready, awlock, wvalid, wready, bvalid, bready;
   logic [31:0] awaddr, wdata, araddr, rdata;
   logic [7:0]  awlen, arlen;
   logic [1:0]  awburst, arburst, bresp, rresp;
   logic [3:0]  awcache, arcache, wstrb;
   logic        arvalid, arready, arlock, rvalid, rready, rlast;

   modport host_end (
      input  mclk, reset, awready, wready, bvalid, bresp, arready, rvalid, rdata, rresp, rlast,
      output awvalid, awaddr, awlen, awburst, awlock, awcache, wvalid, wdata, wstrb, bready,
      output arvalid, araddr, arlen, arburst, arlock, arcache, rready
   );
   modport dev_end (
      input  mclk, reset, awvalid, awaddr, awlen, awburst, awlock, awcache, wvalid, wdata,
      input  wstrb, bready, arvalid, araddr, arlen, arburst, arlock, arcache, rready,
      output awready, wready, bvalid, bresp, arready, rvalid, rdata, rresp, rlast
   );
endinterface : qsp_bus_if

// ===== hdl/qsp_fifo.sv
// first-in first-out buffer with valid/ready on both sides
`timescale 1ns/10ps
module qsp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             reset,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_q, rd_q;
   logic [AW:0]      cnt_q;
   logic             push, pop;

   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem[rd_q];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : qsp_fifo

// ===== hdl/qsp_dev_end.sv
// serial controller end: bus slave, byte fifo and serial shifter
// How it works
// - master sends single-beat INCR only in enhanced
// - only low 8 bits of beat used
// - no FIXED bursts in execute-in-place
// - execute-in-place has no write channel
// - never read and write outstanding together
// - execute-in-place addresses are word aligned
// - no byte accesses in execute-in-place
// - write strobes always contiguous
// - no atomic, locked or cached transactions
// - no slave mode at clock ratio 2
// - first read valid waits for read ready
// - serial source clock is twice bit rate
// - one bus clock and reset serve every mode
// - interrupt low after reset, serial side raises
// - clock pin enable active low, resets high
// - selects one-hot active low, reset all ones
// - select enable active low, resets high
// - select input vector is ignored
// - clock input only for slave mode
// - serial clock is source clock halved
// - data line enables active low, reset high
// - one to thirty-two selects
`timescale 1ns/10ps
`include "qsp_regs.svh"
module qsp_dev_end #(
   parameter qsp_pkg::qsp_mode_t MODE       = qsp_pkg::QSP_ENHANCED,
   parameter int                 NUM_SS     = 1,
   parameter int                 SCK_RATIO  = `QSP_SCK_RATIO,
   parameter bit                 SLAVE_REQ  = 1'b0,
   parameter int                 FIFO_DEPTH = `QSP_FIFO_DEPTH
) (
   // bus side
   qsp_bus_if.dev_end          bus,
   // serial pins
   output logic                sck_out,
   output logic                sck_drive_n,
   input  wire logic           sck_in,
   output logic [NUM_SS-1:0]   ss_n,
   output logic                ss_drive_n,
   input  wire logic [NUM_SS-1:0] ss_in,
   output logic                mosi_out,
   output logic                data_line_drive_n,
   input  wire logic           miso_in,
   // status
   output logic                interrupt_request_out,
   output logic                slave_mode_active
);
   localparam int FW = `QSP_LANE_W + `QSP_SEL_W;
   localparam int NSS = (MODE == qsp_pkg::QSP_XIP) ? 1 : NUM_SS;

   // ------------------------------------------------------------
   // bus slave
   // ------------------------------------------------------------
   qsp_pkg::qsp_bus_st_t bst_q;
   logic                 awready_q, wready_q, bvalid_q, arready_q, rvalid_q, rlast_q;
   logic [1:0]           bresp_q, rresp_q;
   logic [31:0]          rdata_q;
   logic [7:0]           beats_q;
   logic                 wr_err, rd_err, push, wr_take, fifo_in_ready;
   logic [FW-1:0]        fifo_in, fifo_out;
   logic                 fifo_out_valid, fifo_out_ready;
   logic [`QSP_LANE_W-1:0] rx_q;
   logic                 rd_take;

   // refuse what this end does not handle with an error answer
   always_comb begin
      wr_err = (MODE == qsp_pkg::QSP_XIP);
      rd_err = 1'b0;
      if (MODE == qsp_pkg::QSP_ENHANCED) begin
         wr_err = (bus.awlen != 8'h00) || (bus.awburst != `QSP_BURST_INCR);
         rd_err = (bus.arlen != 8'h00) || (bus.arburst != `QSP_BURST_INCR);
      end else if (MODE == qsp_pkg::QSP_XIP) begin
         rd_err = (bus.arburst == `QSP_BURST_FIXED);
      end else begin
         wr_err = (bus.awlen != 8'h00);
         rd_err = (bus.arlen != 8'h00);
      end
   end

   // one direction at a time: write wins when both arrive together
   assign wr_take = (bst_q == qsp_pkg::QB_IDLE) && bus.awvalid && bus.wvalid &&
                    (wr_err || fifo_in_ready);
   assign push    = wr_take && !wr_err;
   assign rd_take = (bst_q == qsp_pkg::QB_IDLE) && bus.arvalid && !(bus.awvalid && bus.wvalid);
   // low byte lane only; the rest of the beat is dropped
   assign fifo_in = {bus.awaddr[`QSP_SEL_LSB +: `QSP_SEL_W],
                     bus.wdata[`QSP_LANE_W-1:0]};

   always_ff @(posedge bus.mclk or posedge bus.reset) begin
      if (bus.reset) begin
         bst_q     <= qsp_pkg::QB_IDLE;
         awready_q <= 1'b0;
         wready_q  <= 1'b0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `QSP_RESP_OKAY;
         arready_q <= 1'b0;
         rvalid_q  <= 1'b0;
         rlast_q   <= 1'b0;
         rresp_q   <= `QSP_RESP_OKAY;
         rdata_q   <= 32'h0000_0000;
         beats_q   <= 8'h00;
      end else begin
         awready_q <= wr_take;
         wready_q  <= wr_take;
         arready_q <= rd_take;
         unique case (bst_q)
            qsp_pkg::QB_IDLE: begin
               if (wr_take) begin
                  bresp_q <= wr_err ? `QSP_RESP_SLVERR : `QSP_RESP_OKAY;
                  bst_q   <= qsp_pkg::QB_BRESP;
               end else if (rd_take) begin
                  rresp_q <= rd_err ? `QSP_RESP_SLVERR : `QSP_RESP_OKAY;
                  beats_q <= bus.arlen;
                  bst_q   <= qsp_pkg::QB_RWAIT;
               end
            end
            qsp_pkg::QB_BRESP: begin
               if (!awready_q) begin
                  bvalid_q <= 1'b1;
               end
               if (bvalid_q && bus.bready) begin
                  bvalid_q <= 1'b0;
                  bst_q    <= qsp_pkg::QB_IDLE;
               end
            end
            qsp_pkg::QB_RWAIT: begin
               if (bus.rready && !arready_q) begin
                  rvalid_q <= 1'b1;
                  rlast_q  <= (beats_q == 8'h00);
                  rdata_q  <= {{(32-`QSP_LANE_W){1'b0}}, rx_q};
                  bst_q    <= qsp_pkg::QB_RDATA;
               end
            end
            qsp_pkg::QB_RDATA: begin
               if (bus.rready) begin
                  if (rlast_q) begin
                     rvalid_q <= 1'b0;
                     rlast_q  <= 1'b0;
                     bst_q    <= qsp_pkg::QB_IDLE;
                  end else begin
                     beats_q <= beats_q - 8'h01;
                     rlast_q <= (beats_q == 8'h01);
                  end
               end
            end
         endcase
      end
   end

   assign bus.awready = awready_q;
   assign bus.wready  = wready_q;
   assign bus.bvalid  = bvalid_q;
   assign bus.bresp   = bresp_q;
   assign bus.arready = arready_q;
   assign bus.rvalid  = rvalid_q;
   assign bus.rlast   = rlast_q;
   assign bus.rresp   = rresp_q;
   assign bus.rdata   = rdata_q;

   // ------------------------------------------------------------
   // byte buffer
   // ------------------------------------------------------------
   qsp_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH)
   ) u_txq (
      .mclk      (bus.mclk),
      .reset     (bus.reset),
      .in_valid  (push),
      .in_ready  (fifo_in_ready),
      .in_data   (fifo_in),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out)
   );

   // ------------------------------------------------------------
   // serial shifter, master only, clock is mclk halved
   // ------------------------------------------------------------
   qsp_pkg::qsp_eng_st_t   est_q;
   logic [`QSP_LANE_W-1:0] sh_q;
   logic [2:0]             bit_q;
   logic                   sck_q, sck_dn_q, ss_dn_q, dat_dn_q, mosi_q, irq_q, slv_q;
   logic [NUM_SS-1:0]      ss_n_q;
   logic [`QSP_SEL_W-1:0]  sel;
   logic                   byte_done;

   assign fifo_out_ready = (est_q == qsp_pkg::QE_IDLE);
   assign sel       = (NSS == 1) ? '0 : fifo_out[FW-1 -: `QSP_SEL_W];
   assign byte_done = (est_q == qsp_pkg::QE_SHIFT) && sck_q && (bit_q == `QSP_BITS_LAST);

   always_ff @(posedge bus.mclk or posedge bus.reset) begin
      if (bus.reset) begin
         est_q    <= qsp_pkg::QE_IDLE;
         sh_q     <= '0;
         rx_q     <= '0;
         bit_q    <= 3'h0;
         sck_q    <= 1'b0;
         mosi_q   <= 1'b0;
         ss_n_q   <= '1;
         sck_dn_q <= `QSP_DRIVE_N_RST;
         ss_dn_q  <= `QSP_DRIVE_N_RST;
         dat_dn_q <= `QSP_DRIVE_N_RST;
      end else begin
         unique case (est_q)
            qsp_pkg::QE_IDLE: begin
               if (fifo_out_valid) begin
                  sh_q     <= fifo_out[`QSP_LANE_W-1:0];
                  mosi_q   <= fifo_out[`QSP_LANE_W-1];
                  bit_q    <= 3'h0;
                  ss_n_q   <= ~(NUM_SS'(1) << sel);
                  sck_dn_q <= 1'b0;
                  ss_dn_q  <= 1'b0;
                  dat_dn_q <= 1'b0;
                  est_q    <= qsp_pkg::QE_SHIFT;
               end
            end
            qsp_pkg::QE_SHIFT: begin
               sck_q <= ~sck_q;
               if (!sck_q) begin
                  rx_q <= {rx_q[`QSP_LANE_W-2:0], miso_in};
               end else if (byte_done) begin
                  ss_n_q   <= '1;
                  sck_dn_q <= `QSP_DRIVE_N_RST;
                  ss_dn_q  <= `QSP_DRIVE_N_RST;
                  dat_dn_q <= `QSP_DRIVE_N_RST;
                  est_q    <= qsp_pkg::QE_IDLE;
               end else begin
                  bit_q  <= bit_q + 3'h1;
                  sh_q   <= {sh_q[`QSP_LANE_W-2:0], 1'b0};
                  mosi_q <= sh_q[`QSP_LANE_W-2];
               end
            end
         endcase
      end
   end

   // ------------------------------------------------------------
   // interrupt and mode status
   // ------------------------------------------------------------
   always_ff @(posedge bus.mclk or posedge bus.reset) begin
      if (bus.reset) begin
         irq_q <= `QSP_IRQ_RST;
      end else if (byte_done) begin
         irq_q <= 1'b1;
      end else if (rd_take) begin
         irq_q <= 1'b0;
      end
   end

   // slave mode would need sck_in; refused at ratio 2, so stays off
   always_ff @(posedge bus.mclk or posedge bus.reset) begin
      if (bus.reset) begin
         slv_q <= 1'b0;
      end else begin
         slv_q <= SLAVE_REQ && (SCK_RATIO > `QSP_SCK_RATIO) &&
                  (MODE != qsp_pkg::QSP_XIP) && (NUM_SS <= `QSP_MAX_SS);
      end
   end

   assign sck_out               = sck_q;
   assign sck_drive_n           = sck_dn_q;
   assign ss_n                  = ss_n_q;
   assign ss_drive_n            = ss_dn_q;
   assign mosi_out              = mosi_q;
   assign data_line_drive_n     = dat_dn_q;
   assign interrupt_request_out = irq_q;
   assign slave_mode_active     = slv_q;
   // ss_in and sck_in are deliberately left unread
   // single mclk/reset serves every mode here
endmodule : qsp_dev_end

// ===== hdl/qsp_host_end.sv
// bus master end: turns user commands into single-beat bus transfers
`timescale 1ns/10ps
`include "qsp_regs.svh"
module qsp_host_end #(
   parameter qsp_pkg::qsp_mode_t MODE = qsp_pkg::QSP_ENHANCED
) (
   // bus side
   qsp_bus_if.host_end   bus,
   // command port
   input  wire logic        cmd_valid,
   output logic             cmd_ready,
   input  wire logic        cmd_write,
   input  wire logic [31:0] cmd_addr,
   input  wire logic [31:0] cmd_data,
   // answer port
   output logic             rsp_valid,
   output logic [31:0]      rsp_data,
   output logic             rsp_err
);
   qsp_pkg::qsp_host_st_t st_q;
   logic        awv_q, wv_q, bready_q, arv_q, rready_q, cmd_ready_q, rsp_valid_q, rsp_err_q;
   logic [31:0] addr_q, data_q, rsp_data_q;
   logic        take;

   assign take = (st_q == qsp_pkg::QH_IDLE) && cmd_ready_q && cmd_valid;

   always_ff @(posedge bus.mclk or posedge bus.reset) begin
      if (bus.reset) begin
         st_q        <= qsp_pkg::QH_IDLE;
         awv_q       <= 1'b0;
         wv_q        <= 1'b0;
         bready_q    <= 1'b0;
         arv_q       <= 1'b0;
         rready_q    <= 1'b0;
         cmd_ready_q <= 1'b0;
         rsp_valid_q <= 1'b0;
         rsp_err_q   <= 1'b0;
         rsp_data_q  <= 32'h0000_0000;
         addr_q      <= 32'h0000_0000;
         data_q      <= 32'h0000_0000;
      end else begin
         rsp_valid_q <= 1'b0;
         unique case (st_q)
            qsp_pkg::QH_IDLE: begin
               cmd_ready_q <= 1'b1;
               if (take) begin
                  cmd_ready_q <= 1'b0;
                  addr_q      <= {cmd_addr[31:2], 2'h0};
                  data_q      <= cmd_data;
                  if (cmd_write && (MODE == qsp_pkg::QSP_XIP)) begin
                     rsp_valid_q <= 1'b1;
                     rsp_err_q   <= 1'b1;
                  end else if (cmd_write) begin
                     awv_q <= 1'b1;
                     wv_q  <= 1'b1;
                     st_q  <= qsp_pkg::QH_WR;
                  end else begin
                     arv_q <= 1'b1;
                     st_q  <= qsp_pkg::QH_AR;
                  end
               end
            end
            qsp_pkg::QH_WR: begin
               if (bus.awready) begin
                  awv_q <= 1'b0;
               end
               if (bus.wready) begin
                  wv_q <= 1'b0;
               end
               if ((bus.awready || !awv_q) && (bus.wready || !wv_q)) begin
                  bready_q <= 1'b1;
                  st_q     <= qsp_pkg::QH_B;
               end
            end
            qsp_pkg::QH_B: begin
               if (bus.bvalid) begin
                  bready_q    <= 1'b0;
                  rsp_valid_q <= 1'b1;
                  rsp_err_q   <= (bus.bresp != `QSP_RESP_OKAY);
                  st_q        <= qsp_pkg::QH_IDLE;
               end
            end
            qsp_pkg::QH_AR: begin
               if (bus.arready) begin
                  arv_q    <= 1'b0;
                  rready_q <= 1'b1;
                  st_q     <= qsp_pkg::QH_R;
               end
            end
            qsp_pkg::QH_R: begin
               if (bus.rvalid && bus.rlast) begin
                  rready_q    <= 1'b0;
                  rsp_valid_q <= 1'b1;
                  rsp_data_q  <= bus.rdata;
                  rsp_err_q   <= (bus.rresp != `QSP_RESP_OKAY);
                  st_q        <= qsp_pkg::QH_IDLE;
               end
            end
         endcase
      end
   end

   // one transfer at a time, single INCR beat, full contiguous word
   assign bus.awvalid = awv_q;
   assign bus.awaddr  = addr_q;
   assign bus.awlen   = 8'h00;
   assign bus.awburst = `QSP_BURST_INCR;
   assign bus.awlock  = 1'b0;
   assign bus.awcache = 4'h0;
   assign bus.wvalid  = wv_q;
   assign bus.wdata   = data_q;
   assign bus.wstrb   = `QSP_STRB_FULL;
   assign bus.bready  = bready_q;
   assign bus.arvalid = arv_q;
   assign bus.araddr  = addr_q;
   assign bus.arlen   = 8'h00;
   assign bus.arburst = `QSP_BURST_INCR;
   assign bus.arlock  = 1'b0;
   assign bus.arcache = 4'h0;
   assign bus.rready  = rready_q;
   assign cmd_ready   = cmd_ready_q;
   assign rsp_valid   = rsp_valid_q;
   assign rsp_data    = rsp_data_q;
   assign rsp_err     = rsp_err_q;
   // serial source clock is mclk, twice the bit rate
endmodule : qsp_host_end

// ===== testbench/qsp_bus_checker.sv
// concurrent checks on the bus link between the two ends
`timescale 1ns/10ps
`include "qsp_regs.svh"
module qsp_bus_checker (
   // clock and reset
   input wire logic        mclk,
   input wire logic        reset,
   // write channels
   input wire logic        awvalid, awready, awlock, wvalid, wready, bvalid, bready,
   input wire logic [7:0]  awlen,
   input wire logic [1:0]  awburst, bresp,
   input wire logic [3:0]  awcache, wstrb,
   // read channels
   input wire logic        arvalid, arready, arlock, rvalid, rready, rlast,
   input wire logic [31:0] araddr, rdata,
   input wire logic [7:0]  arlen,
   input wire logic [1:0]  arburst, rresp,
   input wire logic [3:0]  arcache
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (reset);
   // ------------------------------------------------
   // handshake steps
   // ------------------------------------------------
   sequence s_wr_accept;
      awready && wready;
   endsequence
   sequence s_rd_answer;
      !rvalid ##[1:8] rvalid;
   endsequence
   wr_resp_delay_a: assert property (s_wr_accept |=> !bvalid ##1 bvalid)
      else $error("write response late");
   rd_answer_bound_a: assert property (arready |=> s_rd_answer)
      else $error("read data not within bound");
   rd_wait_ready_a: assert property ($rose(rvalid) |-> $past(rready))
      else $error("read valid raised before read ready");
   rd_single_beat_a: assert property (rvalid |-> rlast)
      else $error("read beat is not the last");
   rd_byte_only_a: assert property ((rvalid && rresp == `QSP_RESP_OKAY) |-> rdata[31:8] == 24'h0)
      else $error("read data above low byte");
   wr_single_incr_a: assert property (awvalid |-> (awlen == 8'h0 && awburst == `QSP_BURST_INCR))
      else $error("write burst not single incr");
   rd_single_incr_a: assert property (arvalid |-> (arlen == 8'h0 && arburst == `QSP_BURST_INCR))
      else $error("read burst not single incr");
   no_atomic_a: assert property ((awvalid || arvalid) |-> !(awlock || arlock || |awcache || |arcache))
      else $error("locked or cached request");
   strb_full_a: assert property (wvalid |-> wstrb == `QSP_STRB_FULL)
      else $error("write strobes not full");
   rd_aligned_a: assert property (arvalid |-> araddr[1:0] == 2'h0)
      else $error("read address unaligned");
   one_dir_a: assert property ((awvalid || wvalid || bvalid) |-> !(arvalid || rvalid))
      else $error("read and write outstanding together");
   bresp_hold_a: assert property ((bvalid && !bready) |=> (bvalid && $stable(bresp)))
      else $error("write response dropped early");
endmodule : qsp_bus_checker

// ===== testbench/tb.sv
// self-checking bench: host end and controller end joined by the bus link
`timescale 1ns/10ps
`include "qsp_regs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
   $display("Error at %0t: got %h expected %h", $time, a, b); end end
`define WAITC(c, n) for (w = 0; w < n && !(c); w++) @(posedge mclk); if (!(c)) timeout();
module tb;
   logic        mclk = 1'b0;
   logic        reset = 1'b1;
   logic        cmd_valid = 1'b0, cmd_write = 1'b0, cmd_ready, rsp_valid, rsp_err;
   logic [31:0] cmd_addr = 32'h0, cmd_data = 32'h0, rsp_data;
   logic        sck_out, sck_drive_n, ss_drive_n, mosi_out, data_drive_n, irq, slave_act, mosi2;
   logic [3:0]  ss_n, seen_ss;
   logic [2:0]  seen_drv;
   int          mismatches = 0, n_compared = 0, w, i, sck_cnt = 0, nbytes = 0;
   int          stall = 0, max_stall = 0;
   time         last_rise = 0, sck_per = 0;
   always #20 mclk = ~mclk;
   qsp_bus_if bus (.mclk(mclk), .reset(reset));
   qsp_bus_if bus2 (.mclk(mclk), .reset(reset));
   qsp_host_end qsp_host_end_i (.bus(bus), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_err(rsp_err));
   // serial data looped back so a read returns the byte just sent
   qsp_dev_end #(.NUM_SS(4)) qsp_dev_end_i (.bus(bus), .sck_out(sck_out),
      .sck_drive_n(sck_drive_n), .sck_in(1'b0), .ss_n(ss_n), .ss_drive_n(ss_drive_n),
      .ss_in(4'h0), .mosi_out(mosi_out), .data_line_drive_n(data_drive_n), .miso_in(mosi_out),
      .interrupt_request_out(irq), .slave_mode_active(slave_act));
   qsp_dev_end qsp_dev_end_i2 (.bus(bus2), .sck_out(), .sck_drive_n(), .sck_in(1'b0), .ss_n(),
      .ss_drive_n(), .ss_in(1'b0), .mosi_out(mosi2), .data_line_drive_n(), .miso_in(mosi2),
      .interrupt_request_out(), .slave_mode_active());
   qsp_bus_checker qsp_bus_checker_i (.mclk(mclk), .reset(reset), .awvalid(bus.awvalid),
      .awready(bus.awready), .awlock(bus.awlock), .wvalid(bus.wvalid), .wready(bus.wready),
      .bvalid(bus.bvalid), .bready(bus.bready), .awlen(bus.awlen), .awburst(bus.awburst),
      .bresp(bus.bresp), .awcache(bus.awcache), .wstrb(bus.wstrb), .arvalid(bus.arvalid),
      .arready(bus.arready), .arlock(bus.arlock), .rvalid(bus.rvalid), .rready(bus.rready),
      .rlast(bus.rlast), .araddr(bus.araddr), .rdata(bus.rdata), .arlen(bus.arlen),
      .arburst(bus.arburst), .rresp(bus.rresp), .arcache(bus.arcache));
   // ------------------------------------------------
   // serial and bus monitors
   // ------------------------------------------------
   always @(posedge sck_out) begin
      sck_cnt++;
      sck_per = $time - last_rise;
      last_rise = $time;
   end
   always @(negedge ss_n[0]) nbytes++;
   always @(negedge mclk) begin
      if (ss_n !== 4'hf) begin
         seen_ss = ss_n;
         seen_drv = {sck_drive_n, ss_drive_n, data_drive_n};
      end
   end
   always @(posedge mclk) begin
      stall = (bus.awvalid && !bus.awready) ? stall + 1 : 0;
      if (stall > max_stall) max_stall = stall;
   end
   // ------------------------------------------------
   // tasks
   // ------------------------------------------------
   task automatic finish_test();
      $display("compared %0d, mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : finish_test
   task automatic timeout();
      mismatches++;
      $display("Error at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
      finish_test();
   endtask : timeout
   task automatic cmd(input logic wr, input logic [31:0] a, input logic [31:0] d);
      @(negedge mclk);
      cmd_valid = 1'b1;
      cmd_write = wr;
      cmd_addr = a;
      cmd_data = d;
      @(posedge mclk);
      `WAITC(cmd_ready, 400)
      @(negedge mclk);
      cmd_valid = 1'b0;
      `WAITC(rsp_valid, 400)
   endtask : cmd
   task automatic t_reset_state();
      `CHK(sck_drive_n, 1'b1);
      `CHK(sck_out, 1'b0);
      `CHK(ss_n, 4'hf);
      `CHK(ss_drive_n, 1'b1);
      `CHK(data_drive_n, 1'b1);
      `CHK(irq, 1'b0);
      `CHK(slave_act, 1'b0);
      $display("test reset_state done");
   endtask : t_reset_state
   task automatic t_byte();
      sck_cnt = 0;
      cmd(1'b1, 32'h0000000c, 32'h123456a5);
      `CHK(rsp_err, 1'b0);
      `WAITC(irq, 400)
      @(negedge mclk);
      `CHK(sck_cnt, 8);
      `CHK(sck_per, 80);
      `CHK(seen_ss, 4'h7);
      `CHK(seen_drv, 3'h0);
      `CHK({sck_drive_n, ss_drive_n, data_drive_n, ss_n}, 7'h7f);
      cmd(1'b0, 32'h0000000c, 32'h0);
      `CHK(rsp_data, 32'h000000a5);
      `CHK(rsp_err, 1'b0);
      @(negedge mclk);
      `CHK(irq, 1'b0);
      $display("test single_byte done");
   endtask : t_byte
   task automatic t_fifo();
      nbytes = 0;
      max_stall = 0;
      // enough writes to outrun the shifter and fill the buffer
      for (i = 0; i < 64; i++) begin
         cmd(1'b1, 32'h0, i);
         `CHK(rsp_err, 1'b0);
      end
      `CHK(max_stall > 5, 1'b1);
      `WAITC(nbytes == 64, 2000)
      `WAITC(ss_n[0], 100)
      cmd(1'b0, 32'h0, 32'h0);
      `CHK(rsp_data, 32'h0000003f);
      `CHK(nbytes, 64);
      $display("test fifo_fill_drain done");
   endtask : t_fifo
   task automatic t_refuse();
      logic [7:0] lens [4] = '{8'h0, 8'h1, 8'h0, 8'h0};
      logic [1:0] bsts [4] = '{`QSP_BURST_INCR, `QSP_BURST_INCR, `QSP_BURST_WRAP, `QSP_BURST_FIXED};
      for (i = 0; i < 4; i++) begin
         @(negedge mclk);
         bus2.awvalid = 1'b1;
         bus2.wvalid = 1'b1;
         bus2.awlen = lens[i];
         bus2.awburst = bsts[i];
         @(posedge mclk);
         `WAITC(bus2.awready, 100)
         @(negedge mclk);
         bus2.awvalid = 1'b0;
         bus2.wvalid = 1'b0;
         `WAITC(bus2.bvalid, 100)
         `CHK(bus2.bresp, (i == 0) ? `QSP_RESP_OKAY : `QSP_RESP_SLVERR);
         @(negedge mclk);
         bus2.arvalid = 1'b1;
         bus2.arlen = lens[i];
         bus2.arburst = bsts[i];
         @(posedge mclk);
         `WAITC(bus2.arready, 100)
         @(negedge mclk);
         bus2.arvalid = 1'b0;
         `WAITC(bus2.rvalid, 100)
         `CHK(bus2.rresp, (i == 0) ? `QSP_RESP_OKAY : `QSP_RESP_SLVERR);
      end
      $display("test burst_refusal done");
   endtask : t_refuse
   initial begin
      {bus2.awvalid, bus2.wvalid, bus2.arvalid, bus2.awlock, bus2.arlock} = 5'h0;
      {bus2.awlen, bus2.arlen, bus2.awcache, bus2.arcache} = 24'h0;
      {bus2.awaddr, bus2.araddr, bus2.wdata} = 96'h0;
      {bus2.awburst, bus2.arburst} = {`QSP_BURST_INCR, `QSP_BURST_INCR};
      {bus2.bready, bus2.rready, bus2.wstrb} = {2'h3, `QSP_STRB_FULL};
      repeat (5) @(posedge mclk);
      @(negedge mclk);
      reset = 1'b0;
      t_reset_state();
      t_byte();
      t_fifo();
      t_refuse();
      finish_test();
   end
endmodule : tb
